// ### core/dpsr_params.svh
// constants for the dual pot serial register control block
`ifndef DPSR_PARAMS_SVH
`define DPSR_PARAMS_SVH

// ****************************************
// frame layout
// ****************************************
`define DPSR_TYPE_MSB     7
`define DPSR_TYPE_LSB     4
`define DPSR_ID_MSB       1
`define DPSR_ID_LSB       0
`define DPSR_OP_MSB       7
`define DPSR_OP_LSB       4
`define DPSR_SLOT_MSB     3
`define DPSR_SLOT_LSB     2
`define DPSR_POT_BIT      0
`define DPSR_BITS_END     5'h18
`define DPSR_STAT_BUSY    0

// ****************************************
// values and timing
// ****************************************
`define DPSR_TAP_MAX      6'h3F
`define DPSR_TAP_MIN      6'h00
`define DPSR_FIRST_SLOT   2'h0
`define DPSR_CLK_KHZ      20000
`define DPSR_T_WR_US      5000
`define DPSR_WR_CYC       (`DPSR_T_WR_US * `DPSR_CLK_KHZ / 1000)

`endif

// ### core/dpsr_pkg.sv
// types shared by the dual pot serial register control block
package dpsr_pkg;

    typedef enum logic [3:0] {
        DPSR_OP_GX_D2W  = 4'h1,
        DPSR_OP_INCDEC  = 4'h2,
        DPSR_OP_RD_ST   = 4'h5,
        DPSR_OP_GX_W2D  = 4'h8,
        DPSR_OP_RD_WCR  = 4'h9,
        DPSR_OP_WR_WCR  = 4'hA,
        DPSR_OP_RD_DR   = 4'hB,
        DPSR_OP_WR_DR   = 4'hC,
        DPSR_OP_XFR_D2W = 4'hD,
        DPSR_OP_XFR_W2D = 4'hE
    } dpsr_op_t;

    typedef enum logic [1:0] {
        DPSR_ST_IDLE  = 2'b00,
        DPSR_ST_FETCH = 2'b01,
        DPSR_ST_LOAD  = 2'b11
    } dpsr_state_t;

endpackage

// ### core/dpsr_sync.sv
// three stage synchroniser, a change counts when stages two and three agree
`timescale 1ns/100ps
module dpsr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r[i] <= 1'b0;
                    s2_r[i] <= 1'b0;
                    s3_r[i] <= 1'b0;
                    q[i]    <= 1'b0;
                end else begin
                    s1_r[i] <= d[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (s2_r[i] == s3_r[i]) begin
                        q[i] <= s3_r[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// ### core/dpsr_mem.sv
// preset slot store, one lane per pot, registered read data
`timescale 1ns/100ps
module dpsr_mem #(
    parameter int W     = 6,
    parameter int LANES = 2,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic               clk,
    input  wire logic [LANES-1:0]   we,
    input  wire logic [AW-1:0]      waddr,
    input  wire logic [LANES*W-1:0] wdata,
    input  wire logic [AW-1:0]      raddr,
    output logic      [LANES*W-1:0] rdata
);
    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            // contents survive reset: they model the nonvolatile cells
            logic [W-1:0] mem [DEPTH] = '{default: '0};
            always_ff @(posedge clk) begin
                if (we[i]) begin
                    mem[waddr] <= wdata[i*W +: W];
                end
                rdata[i*W +: W] <= mem[raddr];
            end
        end
    endgenerate
endmodule

// ### core/dpsr_top.sv
// serial slave and register store of the dual 64 tap potentiometer
//
// Behaviour
// RL1: master opens every sequence with the device type and address byte.
// RL2: upper four bits of first byte must equal the device type.
// RL3: two low bits of first byte must equal the slave id pins.
// RL4: only the device whose id pins match executes; others ignore it.
// RL5: master sends the two middle bits of the first byte as zero.
// RL6: second byte is the instruction, its upper four bits the opcode.
// RL7: preset select bits 00..11 choose preset slot zero to three.
// RL8: low instruction bit picks which wiper position register is used.
// RL9: each pot keeps a 6-bit wiper closing exactly one of 64 taps.
// RL10: wiper changes only by write, preset transfer, step or power-up.
// RL11: at power-up each wiper loads from its pot's first preset slot.
// RL12: wiper is volatile; after power-up it holds the first slot value.
// RL13: each pot has four 6-bit preset slots, host read and written.
// RL14: values copy either way between preset slots and the wiper.
// RL15: a preset slot change is a write cycle lasting at most 5 ms.
// RL16: preset save starts only when chip select rises after full write.
// RL17: write pending flag is returned by the status read command.
// RL18: master waits up to 1 ms after power-up before any access.
// RL19: write pending flag reads one during a write cycle, else zero.
// RL20: in step mode each clock moves the wiper up if input high else down; the code holds it at taps 0 and 63.
// RL21: chip select high clears bit counter and command, discarding parts.
// RL22: on address mismatch output stays undriven until chip select rises.
`timescale 1ns/100ps
`include "dpsr_params.svh"
module dpsr_top #(
    parameter logic [3:0]  DEV_TYPE = 4'hA,  // arbitrary type code
    parameter int unsigned WR_CYC   = `DPSR_WR_CYC,
    parameter int          CNT_W    = 17
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        sck_clk,
    input  wire logic        cs_n,
    input  wire logic        si,
    input  wire logic [1:0]  slave_id_pins,
    output logic             so_o,
    output logic             so_oe_n,
    output logic [63:0]      wiper0_tap,
    output logic [63:0]      wiper1_tap,
    output logic             write_pending_flag
);
    import dpsr_pkg::*;

    function automatic logic op_is_read(input logic [3:0] op);
        op_is_read = (op == DPSR_OP_RD_WCR) || (op == DPSR_OP_RD_DR) ||
                     (op == DPSR_OP_RD_ST);
    endfunction

    function automatic logic op_needs_data(input logic [3:0] op);
        op_needs_data = (op == DPSR_OP_WR_WCR) || (op == DPSR_OP_WR_DR);
    endfunction

    // ****************************************
    // link side, clocked by the serial clock
    // ****************************************
    logic       frame_rst_n;
    logic [4:0] bitcnt_r;
    logic [6:0] shift_r;
    logic       hit_r;
    logic [7:0] instr_r;
    logic       byte_tgl_r;
    logic [7:0] byte_hold_r;
    logic [1:0] byte_idx_r;
    logic       inc_tgl_r;
    logic       dec_tgl_r;
    logic [7:0] byte_in;
    logic       byte_done;
    logic [1:0] byte_idx;
    logic       addr_ok;
    logic       step_mode;
    logic       send_ok;
    logic [1:0] id_s;
    logic       rd_en_r;
    logic [7:0] rd_word_r;

    // chip select high holds the frame logic in reset
    assign frame_rst_n = nrst & ~cs_n;  // [RL21]
    assign byte_in     = {shift_r, si};
    assign byte_idx    = bitcnt_r[4:3];
    assign byte_done   = (bitcnt_r[2:0] == 3'h7) &&
                         (bitcnt_r < `DPSR_BITS_END);
    assign addr_ok     =
        (byte_in[`DPSR_TYPE_MSB:`DPSR_TYPE_LSB] == DEV_TYPE) &&  // [RL2]
        (byte_in[`DPSR_ID_MSB:`DPSR_ID_LSB] == id_s);            // [RL3]
    assign step_mode   = hit_r && (byte_idx >= 2'h2) &&
                         (instr_r[`DPSR_OP_MSB:`DPSR_OP_LSB] == DPSR_OP_INCDEC);
    assign send_ok     = hit_r && (byte_idx == 2'h2) &&
                         op_is_read(instr_r[`DPSR_OP_MSB:`DPSR_OP_LSB]);

    always_ff @(posedge sck_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bitcnt_r <= 5'h00;
            shift_r  <= 7'h00;
            hit_r    <= 1'b0;
            instr_r  <= 8'h00;
        end else begin
            shift_r <= byte_in[6:0];
            if (bitcnt_r < `DPSR_BITS_END) begin
                bitcnt_r <= bitcnt_r + 5'h01;
            end
            if (byte_done && byte_idx == 2'h0) begin
                hit_r <= addr_ok;  // [RL4]
            end
            if (byte_done && byte_idx == 2'h1) begin
                instr_r <= byte_in;  // [RL6]
            end
        end
    end

    // event toggles survive chip select so a last byte is never lost
    always_ff @(posedge sck_clk or negedge nrst) begin
        if (!nrst) begin
            byte_tgl_r  <= 1'b0;
            byte_hold_r <= 8'h00;
            byte_idx_r  <= 2'h0;
            inc_tgl_r   <= 1'b0;
            dec_tgl_r   <= 1'b0;
        end else begin
            if (byte_done && hit_r && !step_mode) begin
                byte_tgl_r  <= ~byte_tgl_r;
                byte_hold_r <= byte_in;
                byte_idx_r  <= byte_idx;
            end
            if (step_mode) begin
                inc_tgl_r <= inc_tgl_r ^ si;   // [RL20]
                dec_tgl_r <= dec_tgl_r ^ ~si;  // [RL20]
            end
        end
    end

    // data leaves on the falling edge; bits 7 and 6 are always zero
    always_ff @(negedge sck_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_o    <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            so_oe_n <= ~send_ok;  // [RL22]
            so_o    <= send_ok & rd_en_r & rd_word_r[~bitcnt_r[2:0]];
        end
    end

    // ****************************************
    // register side, clocked by the system clock
    // ****************************************
    logic        cs_n_s;
    logic        cs_sel_s;
    logic        byte_t_s;
    logic        inc_t_s;
    logic        dec_t_s;
    logic        cs_n_d;
    logic        byte_t_d;
    logic        inc_t_d;
    logic        dec_t_d;
    logic        byte_ev;
    logic        inc_ev;
    logic        dec_ev;
    logic        cs_rise;
    dpsr_op_t    op_r;
    logic        cmd_pot_r;
    logic [1:0]  cmd_slot_r;
    logic [5:0]  data_r;
    logic        have_instr_r;
    logic        have_data_r;
    logic        incdec_r;
    dpsr_state_t state_r;
    dpsr_state_t state_nxt;
    logic        eng_pot_r;
    logic [1:0]  eng_slot_r;
    logic        both_r;
    logic        to_rd_r;
    logic [5:0]  wiper_r [2];
    logic [5:0]  wiper_nxt [2];
    logic [1:0]  w_src;
    logic [1:0]  mem_we;
    logic [11:0] mem_wdata;
    logic [11:0] mem_rdata;
    logic        exec;
    logic        exec_nv;
    logic        start_fetch;
    logic        instr_ev;
    dpsr_op_t    byte_op;
    logic [CNT_W-1:0] wr_cnt_r;

    dpsr_sync #(
        .W (6)
    ) u_sync (
        .clk   (sys_clk),
        .rst_n (nrst),
        .d     ({slave_id_pins, dec_tgl_r, inc_tgl_r, byte_tgl_r, ~cs_n}),
        .q     ({id_s, dec_t_s, inc_t_s, byte_t_s, cs_sel_s})
    );

    // select synced active high so its reset value matches the idle pin
    assign cs_n_s   = ~cs_sel_s;

    assign byte_ev  = byte_t_s ^ byte_t_d;
    assign inc_ev   = inc_t_s ^ inc_t_d;
    assign dec_ev   = dec_t_s ^ dec_t_d;
    assign cs_rise  = cs_n_s & ~cs_n_d;
    assign instr_ev = byte_ev && (byte_idx_r == 2'h1);
    assign byte_op  = dpsr_op_t'(byte_hold_r[`DPSR_OP_MSB:`DPSR_OP_LSB]);
    // complete sequences only, acted on at chip select release
    assign exec     = cs_rise && have_instr_r &&
                      (!op_needs_data(op_r) || have_data_r);  // [RL21]
    assign exec_nv  = exec && !write_pending_flag &&
                      ((op_r == DPSR_OP_WR_DR) ||
                       (op_r == DPSR_OP_XFR_W2D) ||
                       (op_r == DPSR_OP_GX_W2D));  // [RL16]
    assign start_fetch = (state_r == DPSR_ST_IDLE) &&
                         ((exec && (op_r == DPSR_OP_XFR_D2W ||
                                    op_r == DPSR_OP_GX_D2W)) ||
                          (instr_ev && byte_op == DPSR_OP_RD_DR));

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DPSR_ST_IDLE: begin
                if (start_fetch) begin
                    state_nxt = DPSR_ST_FETCH;
                end
            end
            DPSR_ST_FETCH: begin
                state_nxt = DPSR_ST_LOAD;
            end
            DPSR_ST_LOAD: begin
                state_nxt = DPSR_ST_IDLE;
            end
            default: begin
                state_nxt = DPSR_ST_IDLE;
            end
        endcase
    end

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pot
            logic ld;
            logic wr;
            logic up;
            logic dn;
            assign ld = (state_r == DPSR_ST_LOAD) && !to_rd_r &&
                        (both_r || eng_pot_r == 1'(p));  // [RL14]
            assign wr = exec && op_r == DPSR_OP_WR_WCR &&
                        cmd_pot_r == 1'(p);  // [RL8]
            assign up = incdec_r && cmd_pot_r == 1'(p) && inc_ev &&
                        !dec_ev && wiper_r[p] != `DPSR_TAP_MAX;  // [RL20]
            assign dn = incdec_r && cmd_pot_r == 1'(p) && dec_ev &&
                        !inc_ev && wiper_r[p] != `DPSR_TAP_MIN;  // [RL20]
            assign w_src[p] = ld | wr | up | dn;
            assign wiper_nxt[p] = ld ? mem_rdata[p*6 +: 6] :
                                  wr ? data_r :
                                  up ? wiper_r[p] + 6'h01 :
                                  dn ? wiper_r[p] - 6'h01 :
                                  wiper_r[p];  // [RL10]
            assign mem_we[p] = exec_nv && (op_r == DPSR_OP_GX_W2D ||
                                           cmd_pot_r == 1'(p));  // [RL14]
            assign mem_wdata[p*6 +: 6] =
                (op_r == DPSR_OP_WR_DR) ? data_r : wiper_r[p];  // [RL13]
        end
    endgenerate

    dpsr_mem #(
        .W     (6),
        .LANES (2),
        .DEPTH (4),
        .AW    (2)
    ) u_mem (
        .clk   (sys_clk),
        .we    (mem_we),
        .waddr (cmd_slot_r),
        .wdata (mem_wdata),
        .raddr (eng_slot_r),  // [RL7]
        .rdata (mem_rdata)
    );

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cs_n_d   <= 1'b1;
            byte_t_d <= 1'b0;
            inc_t_d  <= 1'b0;
            dec_t_d  <= 1'b0;
        end else begin
            cs_n_d   <= cs_n_s;
            byte_t_d <= byte_t_s;
            inc_t_d  <= inc_t_s;
            dec_t_d  <= dec_t_s;
        end
    end

    // command capture; cleared whenever chip select rises
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            op_r         <= DPSR_OP_RD_ST;
            cmd_pot_r    <= 1'b0;
            cmd_slot_r   <= 2'h0;
            data_r       <= 6'h00;
            have_instr_r <= 1'b0;
            have_data_r  <= 1'b0;
            incdec_r     <= 1'b0;
        end else if (cs_rise) begin
            have_instr_r <= 1'b0;  // [RL21]
            have_data_r  <= 1'b0;
            incdec_r     <= 1'b0;
        end else if (instr_ev) begin
            op_r         <= byte_op;  // [RL6]
            cmd_slot_r   <= byte_hold_r[`DPSR_SLOT_MSB:`DPSR_SLOT_LSB];
            cmd_pot_r    <= byte_hold_r[`DPSR_POT_BIT];  // [RL8]
            have_instr_r <= 1'b1;
            incdec_r     <= (byte_op == DPSR_OP_INCDEC);
        end else if (byte_ev && byte_idx_r == 2'h2) begin
            data_r       <= byte_hold_r[5:0];
            have_data_r  <= have_instr_r;
        end
    end

    // fetch engine; reset starts a load of the first slot into both wipers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= DPSR_ST_FETCH;  // [RL11]
            eng_slot_r <= `DPSR_FIRST_SLOT;
            eng_pot_r  <= 1'b0;
            both_r     <= 1'b1;
            to_rd_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (start_fetch) begin
                eng_slot_r <= exec ? cmd_slot_r :
                              byte_hold_r[`DPSR_SLOT_MSB:`DPSR_SLOT_LSB];
                eng_pot_r  <= exec ? cmd_pot_r : byte_hold_r[`DPSR_POT_BIT];
                both_r     <= exec && op_r == DPSR_OP_GX_D2W;
                to_rd_r    <= !exec;
            end
        end
    end

    // volatile wipers clear on power loss and are reloaded by the engine
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wiper_r[0] <= 6'h00;  // [RL12]
            wiper_r[1] <= 6'h00;
            wiper0_tap <= 64'h0000_0000_0000_0001;
            wiper1_tap <= 64'h0000_0000_0000_0001;
        end else begin
            wiper_r[0] <= wiper_nxt[0];
            wiper_r[1] <= wiper_nxt[1];
            wiper0_tap <= 64'h1 << wiper_r[0];  // [RL9]
            wiper1_tap <= 64'h1 << wiper_r[1];  // [RL9]
        end
    end

    // read word for the data byte and the write cycle timer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_en_r            <= 1'b0;
            rd_word_r          <= 8'h00;
            wr_cnt_r           <= '0;
            write_pending_flag <= 1'b0;
        end else begin
            if (cs_rise) begin
                rd_en_r <= 1'b0;
            end else if (instr_ev && byte_op == DPSR_OP_RD_WCR) begin
                rd_en_r   <= 1'b1;
                rd_word_r <= {2'h0, wiper_r[byte_hold_r[`DPSR_POT_BIT]]};
            end else if (instr_ev && byte_op == DPSR_OP_RD_ST) begin
                rd_en_r   <= 1'b1;
                rd_word_r <= {7'h00, write_pending_flag};  // [RL17]
            end else if (state_r == DPSR_ST_LOAD && to_rd_r) begin
                rd_en_r   <= 1'b1;
                rd_word_r <= {2'h0, mem_rdata[eng_pot_r*6 +: 6]};  // [RL13]
            end
            if (|mem_we) begin
                wr_cnt_r           <= CNT_W'(WR_CYC - 1);  // [RL15]
                write_pending_flag <= 1'b1;                // [RL19]
            end else begin
                if (wr_cnt_r != '0) begin
                    wr_cnt_r <= wr_cnt_r - 1'b1;
                end
                write_pending_flag <= write_pending_flag &&
                                      (wr_cnt_r != '0);  // [RL19]
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [CNT_W-1:0] pend_len_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pend_len_r <= '0;
        end else begin
            pend_len_r <= write_pending_flag ? pend_len_r + 1'b1 : '0;
        end
    end

    property p_boot_load;
        @(posedge sys_clk) disable iff (!nrst)
        (state_r == DPSR_ST_LOAD && both_r && !to_rd_r) |=>
            (wiper_r[0] == $past(mem_rdata[5:0]) &&
             wiper_r[1] == $past(mem_rdata[11:6]));
    endproperty
    a_boot_load: assert property (p_boot_load)  // [RL11] [RL14]
        else $error("wiper not loaded from preset slot");

    property p_tap_onehot;
        @(posedge sys_clk) disable iff (!nrst)
        ##1 (wiper0_tap == (64'h1 << $past(wiper_r[0]))) && $onehot(wiper1_tap);
    endproperty
    a_tap_onehot: assert property (p_tap_onehot)  // [RL9]
        else $error("tap decode wrong");

    property p_inc_step;
        @(posedge sys_clk) disable iff (!nrst)
        (g_pot[0].up && !g_pot[0].ld && !g_pot[0].wr) |=>
            wiper_r[0] == $past(wiper_r[0]) + 6'h01;
    endproperty
    a_inc_step: assert property (p_inc_step)  // [RL20]
        else $error("increment step wrong");

    property p_dec_floor;
        @(posedge sys_clk) disable iff (!nrst)
        (incdec_r && dec_ev && !inc_ev && wiper_r[1] == 6'h00 &&
         !g_pot[1].ld) |=> wiper_r[1] == 6'h00;
    endproperty
    a_dec_floor: assert property (p_dec_floor)  // [RL20]
        else $error("decrement wrapped below zero");

    property p_pend_max;
        @(posedge sys_clk) disable iff (!nrst)
        write_pending_flag |-> pend_len_r < CNT_W'(WR_CYC);
    endproperty
    a_pend_max: assert property (p_pend_max)  // [RL15] [RL19]
        else $error("write cycle too long");

    property p_nv_on_cs;
        @(posedge sys_clk) disable iff (!nrst)
        (|mem_we) |-> cs_rise ##1 write_pending_flag;
    endproperty
    a_nv_on_cs: assert property (p_nv_on_cs)  // [RL16] [RL19]
        else $error("preset write outside chip select release");

    property p_wiper_hold;
        @(posedge sys_clk) disable iff (!nrst)
        (w_src == 2'b00) |=> $stable(wiper_r[0]) && $stable(wiper_r[1]);
    endproperty
    a_wiper_hold: assert property (p_wiper_hold)  // [RL10]
        else $error("wiper changed without cause");

    property p_status_word;
        @(posedge sys_clk) disable iff (!nrst)
        (instr_ev && byte_op == DPSR_OP_RD_ST && !cs_rise) |=>
            rd_en_r && rd_word_r == {7'h00, $past(write_pending_flag)};
    endproperty
    a_status_word: assert property (p_status_word)  // [RL17]
        else $error("status word wrong");

    property p_cs_clear;
        @(posedge sys_clk) disable iff (!nrst)
        cs_rise |=> !have_instr_r && !incdec_r && !rd_en_r;
    endproperty
    a_cs_clear: assert property (p_cs_clear)  // [RL21]
        else $error("command survived chip select");

    property p_reject;
        @(posedge sck_clk) disable iff (!frame_rst_n)
        (byte_done && byte_idx == 2'h0 && !addr_ok) |=> !hit_r [*3];
    endproperty
    a_reject: assert property (p_reject)  // [RL2] [RL3] [RL4]
        else $error("mismatched address accepted");

    property p_quiet;
        @(negedge sck_clk) disable iff (!frame_rst_n)
        !hit_r |=> so_oe_n;
    endproperty
    a_quiet: assert property (p_quiet)  // [RL22]
        else $error("output driven without address match");

    c_boot: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_r == DPSR_ST_LOAD && both_r);
    c_step: cover property (@(posedge sys_clk) disable iff (!nrst)
        g_pot[0].up ##[1:40] g_pot[0].dn);
    c_nv: cover property (@(posedge sys_clk) disable iff (!nrst)
        $fell(write_pending_flag));
    c_read: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_r == DPSR_ST_LOAD && to_rd_r);
endmodule

// ### verif/dpsr_host_model.sv
// spi host master model, mode 0, one frame per call
`timescale 1ns/100ps
module dpsr_host_model (
    input  wire logic lnk_clk,
    input  wire logic so_o,
    output logic      sck_clk,
    output logic      cs_n,
    output logic      si
);
    initial begin
        sck_clk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // sck stands low outside frames; a half bit lasts 7 link periods
    task automatic frame(input logic [23:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        @(posedge lnk_clk) #2 cs_n = 1'b0;
        repeat (8) @(posedge lnk_clk);
        for (int i = 0; i < n; i++) begin
            #2 si = tx[23-i];
            repeat (7) @(posedge lnk_clk);
            #2 sck_clk = 1'b1;
            rx = {rx[6:0], so_o};
            repeat (7) @(posedge lnk_clk);
            #2 sck_clk = 1'b0;
        end
        repeat (8) @(posedge lnk_clk);
        #2 cs_n = 1'b1;
        si = ~si;
        repeat (8) @(posedge lnk_clk);
    endtask
endmodule

// ### verif/test_dual_pot_spi_register_control.sv
// self-checking bench of the dual pot serial register block
`timescale 1ns/100ps
module test_dual_pot_spi_register_control;
    import dpsr_pkg::*;
    logic sys_clk = 1'b0, lnk_clk = 1'b0, nrst = 1'b0;
    logic sck_clk, cs_n, si, so_o, so_oe_n, write_pending_flag;
    logic [63:0] wiper0_tap, wiper1_tap;
    logic [7:0] rx;
    int bad_count = 0, compares = 0, cyc = 0, oe_cnt = 0;
    always #25 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #16 lnk_clk = ~lnk_clk;
    end
    dpsr_top #(.WR_CYC(400)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .sck_clk(sck_clk), .cs_n(cs_n), .si(si), .slave_id_pins(2'h2),
        .so_o(so_o), .so_oe_n(so_oe_n), .wiper0_tap(wiper0_tap),
        .wiper1_tap(wiper1_tap), .write_pending_flag(write_pending_flag));
    dpsr_host_model host (.lnk_clk(lnk_clk), .so_o(so_o),
        .sck_clk(sck_clk), .cs_n(cs_n), .si(si));
    always @(negedge so_oe_n) oe_cnt++;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic cmd(input logic [3:0] ty, input logic [1:0] id,
                       input logic [7:0] ins, input logic [7:0] d, int n);
        host.frame({ty, 2'b00, id, ins, d}, n, rx);
        repeat (10) @(posedge sys_clk);
    endtask
    task automatic t_reset(input logic [63:0] e0, input logic [63:0] e1);
        #2 nrst = 1'b0;
        repeat (16) @(posedge sys_clk);
        #2 nrst = 1'b1;
        repeat (40) @(posedge sys_clk);
        chk(wiper0_tap, e0);
        chk(wiper1_tap, e1);
        chk(write_pending_flag, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_wiper();
        cmd(4'hA, 2'h2, {DPSR_OP_WR_WCR, 4'h1}, 8'h2A, 24);
        chk(wiper1_tap, 64'h1 << 42);
        chk(wiper0_tap, 64'h1);
        cmd(4'hA, 2'h2, {DPSR_OP_RD_WCR, 4'h1}, 8'h00, 24);
        chk(rx, 8'h2A);
        $display("wiper test done");
    endtask
    task automatic t_preset();
        cmd(4'hA, 2'h2, {DPSR_OP_WR_DR, 4'h8}, 8'h15, 24);
        chk(write_pending_flag, 1'b1);
        cmd(4'hA, 2'h2, {DPSR_OP_RD_ST, 4'h1}, 8'h00, 24);
        chk(rx[0], 1'b1);
        for (int i = 0; i < 500 && write_pending_flag !== 1'b0; i++)
            @(posedge sys_clk);
        chk(write_pending_flag, 1'b0);
        cmd(4'hA, 2'h2, {DPSR_OP_RD_DR, 4'h8}, 8'h00, 24);
        chk(rx, 8'h15);
        cmd(4'hA, 2'h2, {DPSR_OP_XFR_D2W, 4'h8}, 8'h00, 16);
        chk(wiper0_tap, 64'h1 << 21);
        $display("preset test done");
    endtask
    task automatic t_refuse();
        int oe0;
        oe0 = oe_cnt;
        cmd(4'hA, 2'h2, {DPSR_OP_WR_WCR, 4'h0}, 8'h3F, 20);
        chk(wiper0_tap, 64'h1 << 21);
        cmd(4'hA, 2'h1, {DPSR_OP_WR_WCR, 4'h0}, 8'h3F, 24);
        chk(wiper0_tap, 64'h1 << 21);
        cmd(4'h3, 2'h2, {DPSR_OP_WR_WCR, 4'h0}, 8'h3F, 24);
        chk(wiper0_tap, 64'h1 << 21);
        cmd(4'hA, 2'h1, {DPSR_OP_RD_WCR, 4'h0}, 8'h00, 24);
        chk(oe_cnt, oe0);
        cmd(4'hA, 2'h2, {DPSR_OP_INCDEC, 4'h0}, 8'hE0, 21);
        chk(wiper0_tap, 64'h1 << 22);
        $display("refuse and step test done");
    endtask
    task automatic t_global();
        cmd(4'hA, 2'h2, {DPSR_OP_GX_W2D, 4'h0}, 8'h00, 16);
        chk(write_pending_flag, 1'b1);
        t_reset(64'h1 << 22, 64'h1 << 42);
        cmd(4'hA, 2'h2, {DPSR_OP_GX_D2W, 4'h8}, 8'h00, 16);
        chk(wiper0_tap, 64'h1 << 21);
        chk(wiper1_tap, 64'h1);
        cmd(4'hA, 2'h2, {DPSR_OP_INCDEC, 4'h1}, 8'h00, 18);
        chk(wiper1_tap, 64'h1);
        $display("global transfer test done");
    endtask
    initial begin
        t_reset(64'h1, 64'h1);
        t_wiper();
        t_preset();
        t_refuse();
        t_global();
        conclude();
    end
endmodule
